// *** rtl/mrh_consts.vh ***
// Constants for the mask ROM host: timing, geometry and card layout.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef MRH_CONSTS_VH
`define MRH_CONSTS_VH

`define MRH_CLK_MHZ      50
`define MRH_ACC_ADDR_NS  450
`define MRH_ACC_CS_NS    200
`define MRH_DIS_NS       200
`define MRH_CYC_NS       450
`define MRH_ACC_CYC      ((`MRH_ACC_ADDR_NS * `MRH_CLK_MHZ + 999) / 1000)
`define MRH_DIS_CYC      ((`MRH_DIS_NS * `MRH_CLK_MHZ + 999) / 1000)

`define MRH_ADDR_W       12
`define MRH_DATA_W       8
`define MRH_WORDS_PER_REC 32
`define MRH_LAST_WORD    5'h1f
`define MRH_LAST_REC     7'h7f

`define MRH_COL_ADDR_HI  7'h01
`define MRH_COL_ADDR_MID 7'h02
`define MRH_COL_ADDR_LO  7'h03
`define MRH_COL_BLANK    7'h04
`define MRH_COL_DATA0    7'h05
`define MRH_COL_DATA_END 7'h44
`define MRH_COL_CKS_HI   7'h45
`define MRH_COL_CKS_LO   7'h46
`define MRH_COL_CS2      7'h49
`define MRH_COL_CS1      7'h4a
`define MRH_COL_ID0      7'h4b
`define MRH_COL_ID_END   7'h50
`define MRH_COL_EOL      7'h51

`define MRH_CH_SPACE     8'h20
`define MRH_CH_ZERO      8'h30
`define MRH_CH_ONE       8'h31
`define MRH_CH_LF        8'h0a

`endif

// *** rtl/mrh_rec_mem.v ***
// Record buffer: 32 words of 8 bits, one write port, registered read.
// Assumes writer and reader share the system clock.
`timescale 1ns/1ns
`default_nettype none
module mrh_rec_mem (
  // Clock
  input  wire       sys_clk_in,
  // Write side
  input  wire       wr_en_in,
  input  wire [4:0] wr_addr_in,
  input  wire [7:0] wr_data_in,
  // Read side
  input  wire [4:0] rd_addr_in,
  output reg  [7:0] rd_data_out
);
  reg [7:0] mem_r [0:31];

  always @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule
`default_nettype wire

// *** rtl/mrh_ctrl.v ***
// Host controller for a static 4096 x 8 mask ROM: single reads and a full card-image dump.
// Assumes the ROM pins are wired directly; data pins come from outside the clock domain.
//
// Overview of operation
// - Image covers 0 to 4095, hex bytes
// - Image is 128 records of 32 words
// - Address cols 1-3, blank 4, data 5-68
// - Checksum negates modulo-256 sum, cols 69-70
// - Col 73 second polarity, 74 first polarity
`timescale 1ns/1ns
`default_nettype none
`include "mrh_consts.vh"
module mrh_ctrl #(
  parameter [47:0] CARD_ID = 48'h515130303030 // Arbitrary device number text
) (
  // Clock and reset
  input  wire        sys_clk_in,
  input  wire        reset_n_in,
  // Chip select polarity straps, 1 is active high
  input  wire        cs_first_pol_in,
  input  wire        cs_second_pol_in,
  // Single read port
  input  wire        rd_req_in,
  input  wire [11:0] rd_addr_in,
  output wire        rd_ready_out,
  output reg         rd_ack_out,
  output reg  [7:0]  rd_data_out,
  // Card image stream
  input  wire        dump_start_in,
  output wire        dump_busy_out,
  output reg         char_valid_out,
  output reg  [7:0]  char_data_out,
  input  wire        char_ready_in,
  // ROM pins
  output reg  [11:0] rom_addr_out,
  output wire        rom_cs_first_out,
  output wire        rom_cs_second_out,
  input  wire [7:0]  rom_data_in
);
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_SEL   = 7'h02;
  localparam [6:0] ST_CAPT  = 7'h04;
  localparam [6:0] ST_GAP   = 7'h08;
  localparam [6:0] ST_FETCH = 7'h10;
  localparam [6:0] ST_BUILD = 7'h20;
  localparam [6:0] ST_SEND  = 7'h40;
  localparam integer ACC_I  = `MRH_ACC_CYC;
  localparam integer DIS_I  = `MRH_DIS_CYC;
  localparam [5:0] ACC_C    = ACC_I[5:0];
  localparam [5:0] DIS_C    = DIS_I[5:0];

  reg [6:0] state_r;
  reg [5:0] cnt_r;
  reg       cs_on_r;
  reg       dump_r;
  reg [4:0] word_r;
  reg [6:0] rec_r;
  reg [6:0] col_r;
  reg [7:0] sum_r;
  reg [7:0] q1_r;
  reg [7:0] q2_r;
  reg [7:0] q3_r;
  reg [7:0] ch_nxt;

  wire [7:0]  mem_rdata;
  wire [6:0]  cm5  = col_r - `MRH_COL_DATA0;
  wire [6:0]  cid  = col_r - `MRH_COL_ID0;
  wire [11:0] rec_base = {rec_r, 5'h00};
  wire [7:0]  cks  = 8'h00 - sum_r;
  wire        mem_we = (state_r == ST_CAPT) && dump_r && (q2_r == q3_r);

  function [7:0] hex_char;
    input [3:0] n;
    begin
      hex_char = (n < 4'ha) ? (`MRH_CH_ZERO + {4'h0, n}) : (8'h37 + {4'h0, n});
    end
  endfunction

  assign rd_ready_out      = (state_r == ST_IDLE);
  assign dump_busy_out     = dump_r;
  assign rom_cs_first_out  = cs_on_r ? cs_first_pol_in : ~cs_first_pol_in;
  assign rom_cs_second_out = cs_on_r ? cs_second_pol_in : ~cs_second_pol_in;

  mrh_rec_mem u_mem (
    .sys_clk_in  (sys_clk_in),
    .wr_en_in    (mem_we),
    .wr_addr_in  (word_r),
    .wr_data_in  (q3_r),
    .rd_addr_in  (cm5[5:1]),
    .rd_data_out (mem_rdata)
  );

  // Card character for the current column
  always @* begin
    ch_nxt = `MRH_CH_SPACE;
    if (col_r == `MRH_COL_ADDR_HI) begin
      ch_nxt = hex_char(rec_base[11:8]);
    end else if (col_r == `MRH_COL_ADDR_MID) begin
      ch_nxt = hex_char(rec_base[7:4]);
    end else if (col_r == `MRH_COL_ADDR_LO) begin
      ch_nxt = hex_char(rec_base[3:0]);
    end else if (col_r >= `MRH_COL_DATA0 && col_r <= `MRH_COL_DATA_END) begin
      ch_nxt = cm5[0] ? hex_char(mem_rdata[3:0]) : hex_char(mem_rdata[7:4]);
    end else if (col_r == `MRH_COL_CKS_HI) begin
      ch_nxt = hex_char(cks[7:4]);
    end else if (col_r == `MRH_COL_CKS_LO) begin
      ch_nxt = hex_char(cks[3:0]);
    end else if (col_r == `MRH_COL_CS2) begin
      ch_nxt = cs_second_pol_in ? `MRH_CH_ONE : `MRH_CH_ZERO;
    end else if (col_r == `MRH_COL_CS1) begin
      ch_nxt = cs_first_pol_in ? `MRH_CH_ONE : `MRH_CH_ZERO;
    end else if (col_r >= `MRH_COL_ID0 && col_r <= `MRH_COL_ID_END) begin
      ch_nxt = CARD_ID[8 * (5 - cid[2:0]) +: 8];
    end else if (col_r == `MRH_COL_EOL) begin
      ch_nxt = `MRH_CH_LF;
    end
  end

  // Data pin synchroniser
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q1_r <= 8'h00;
      q2_r <= 8'h00;
      q3_r <= 8'h00;
    end else begin
      q1_r <= rom_data_in;
      q2_r <= q1_r;
      q3_r <= q2_r;
    end
  end

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r        <= ST_IDLE;
      cnt_r          <= 6'h00;
      cs_on_r        <= 1'b0;
      dump_r         <= 1'b0;
      word_r         <= 5'h00;
      rec_r          <= 7'h00;
      col_r          <= 7'h00;
      sum_r          <= 8'h00;
      rom_addr_out   <= 12'h000;
      rd_ack_out     <= 1'b0;
      rd_data_out    <= 8'h00;
      char_valid_out <= 1'b0;
      char_data_out  <= 8'h00;
    end else begin
      rd_ack_out <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          cnt_r <= 6'h00;
          if (dump_start_in) begin
            dump_r       <= 1'b1;
            rec_r        <= 7'h00;
            word_r       <= 5'h00;
            rom_addr_out <= 12'h000;
            cs_on_r      <= 1'b1;
            state_r      <= ST_SEL;
          end else if (rd_req_in) begin
            rom_addr_out <= rd_addr_in;
            cs_on_r      <= 1'b1;
            state_r      <= ST_SEL;
          end
        end
        ST_SEL: begin
          if (cnt_r == ACC_C) begin
            state_r <= ST_CAPT;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        ST_CAPT: begin
          if (q2_r == q3_r) begin
            cs_on_r <= 1'b0;
            cnt_r   <= 6'h00;
            state_r <= ST_GAP;
            if (!dump_r) begin
              rd_data_out <= q3_r;
              rd_ack_out  <= 1'b1;
            end
          end
        end
        ST_GAP: begin
          if (cnt_r == DIS_C) begin
            cnt_r <= 6'h00;
            if (!dump_r) begin
              state_r <= ST_IDLE;
            end else if (word_r != `MRH_LAST_WORD) begin
              word_r       <= word_r + 5'h01;
              rom_addr_out <= {rec_r, word_r + 5'h01};
              cs_on_r      <= 1'b1;
              state_r      <= ST_SEL;
            end else begin
              col_r   <= `MRH_COL_ADDR_HI;
              sum_r   <= 8'h00;
              state_r <= ST_FETCH;
            end
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        ST_FETCH: begin
          state_r <= ST_BUILD;
        end
        ST_BUILD: begin
          char_data_out  <= ch_nxt;
          char_valid_out <= 1'b1;
          state_r        <= ST_SEND;
        end
        ST_SEND: begin
          if (char_ready_in) begin
            char_valid_out <= 1'b0;
            if (col_r <= `MRH_COL_DATA_END && col_r != `MRH_COL_BLANK) begin
              sum_r <= sum_r + char_data_out;
            end
            if (col_r != `MRH_COL_EOL) begin
              col_r   <= col_r + 7'h01;
              state_r <= ST_FETCH;
            end else if (rec_r == `MRH_LAST_REC) begin
              dump_r  <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              rec_r        <= rec_r + 7'h01;
              word_r       <= 5'h00;
              rom_addr_out <= {rec_r + 7'h01, 5'h00};
              cs_on_r      <= 1'b1;
              state_r      <= ST_SEL;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
          cs_on_r <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** sim/mrh_rom_model.sv ***
// ROM model: static 4096 x 8 word store with two selects.
// Assumes its polarity straps follow the host's polarity inputs.
`timescale 1ns/1ns
`default_nettype none
module mrh_rom_model (
  // Pins and straps
  input  wire [11:0] addr_in,
  input  wire        cs_first_in,
  input  wire        cs_second_in,
  input  wire        pol_first_in,
  input  wire        pol_second_in,
  output wire [7:0]  data_out
);
  wire [7:0] word = addr_in[7:0] ^ {2{addr_in[11:8]}};
  wire       sel  = (cs_first_in == pol_first_in) && (cs_second_in == pol_second_in);
  // Released bus shows the inverse word 300 ns later; reselected sooner, it keeps the old word
  assign #300 data_out = sel ? word : ~word;
endmodule
`default_nettype wire

// *** sim/mrh_ctrl_sva.sv ***
// Checker for the ROM host: selects, address and stream timing.
// Assumes binding to mrh_ctrl; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module mrh_ctrl_sva (
  // Watched ports
  input wire        sys_clk_in,
  input wire        reset_n_in,
  input wire        cs_first_pol_in,
  input wire        cs_second_pol_in,
  input wire        rd_req_in,
  input wire [11:0] rd_addr_in,
  input wire        rd_ready_out,
  input wire        rd_ack_out,
  input wire        dump_start_in,
  input wire        char_valid_out,
  input wire [7:0]  char_data_out,
  input wire        char_ready_in,
  input wire [11:0] rom_addr_out,
  input wire        rom_cs_first_out,
  input wire        rom_cs_second_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire on1 = rom_cs_first_out == cs_first_pol_in;
  wire on2 = rom_cs_second_out == cs_second_pol_in;
  wire on  = on1 && on2;
  sequence s_take; rd_ready_out && rd_req_in && !dump_start_in; endsequence
  sequence s_wait; (on && !rd_ack_out) [*8]; endsequence
  a_sel_pair: assert property (on1 == on2) else $error("selects split");
  a_take_addr: assert property (s_take |=> on && rom_addr_out == $past(rd_addr_in))
    else $error("address not driven");
  a_no_early: assert property (s_take |=> s_wait) else $error("early sample");
  a_ack_time: assert property (s_take |-> ##26 rd_ack_out) else $error("ack late");
  a_ack_float: assert property (rd_ack_out |-> !on1 && !on2) else $error("no release");
  a_addr_hold: assert property (on && $past(on) |-> $stable(rom_addr_out))
    else $error("address moved");
  a_gap_ready: assert property (rd_ack_out |-> !rd_ready_out ##11 rd_ready_out)
    else $error("gap wrong");
  a_char_hold: assert property (char_valid_out && !char_ready_in |=>
    char_valid_out && $stable(char_data_out)) else $error("char dropped");
endmodule
bind mrh_ctrl mrh_ctrl_sva u_sva (.sys_clk_in, .reset_n_in, .cs_first_pol_in,
  .cs_second_pol_in, .rd_req_in, .rd_addr_in, .rd_ready_out, .rd_ack_out,
  .dump_start_in, .char_valid_out, .char_data_out, .char_ready_in, .rom_addr_out,
  .rom_cs_first_out, .rom_cs_second_out);
`default_nettype wire

// *** sim/tb.sv ***
// Testbench for the ROM host: reads, first image record, mid-run reset.
// Assumes the ROM model answers within the host's access wait.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam [47:0] ID = 48'h515130303030; // Arbitrary device number text
  reg         sys_clk_in = 1'b0;
  reg         reset_n_in = 1'b0;
  reg         pol1 = 1'b0;
  reg         pol2 = 1'b0;
  reg         rd_req = 1'b0;
  reg  [11:0] rd_addr = 12'h000;
  reg         dump = 1'b0;
  reg         crdy = 1'b0;
  wire        rdy, ack, busy, cval, cs1, cs2;
  wire [7:0]  rdat, cdat, q;
  wire [11:0] ra;
  integer     n_mismatch = 0;
  integer     checks_done = 0;
  integer     i, k;
  reg  [7:0]  c, e, w, sum, cks;
  reg         got;
  always #10 sys_clk_in = ~sys_clk_in;
  mrh_ctrl #(.CARD_ID(ID)) DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .cs_first_pol_in(pol1), .cs_second_pol_in(pol2), .rd_req_in(rd_req),
    .rd_addr_in(rd_addr), .rd_ready_out(rdy), .rd_ack_out(ack), .rd_data_out(rdat),
    .dump_start_in(dump), .dump_busy_out(busy), .char_valid_out(cval),
    .char_data_out(cdat), .char_ready_in(crdy), .rom_addr_out(ra),
    .rom_cs_first_out(cs1), .rom_cs_second_out(cs2), .rom_data_in(q));
  mrh_rom_model u_rom (.addr_in(ra), .cs_first_in(cs1), .cs_second_in(cs2),
    .pol_first_in(pol1), .pol_second_in(pol2), .data_out(q));
  function [7:0] hx(input [3:0] v);
    hx = (v < 4'ha) ? 8'h30 + v : 8'h37 + v;
  endfunction
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error t=%0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("Counts: %0d mismatches, %0d checks", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task t_read(input [11:0] a);
    begin
      @(negedge sys_clk_in);
      rd_addr = a;
      rd_req = 1'b1;
      @(negedge sys_clk_in);
      rd_req = 1'b0;
      got = 1'b0;
      for (k = 0; k < 60 && !got; k = k + 1) begin
        @(posedge sys_clk_in);
        #1 got = (ack === 1'b1);
      end
      if (!got) begin
        n_mismatch = n_mismatch + 1;
        end_sim;
      end
      chk(rdat, a[7:0] ^ {2{a[11:8]}});
      for (k = 0; k < 30 && rdy !== 1'b1; k = k + 1) @(posedge sys_clk_in) #1;
      chk({7'h00, rdy}, 8'h01);
    end
  endtask
  task get_ch(output [7:0] ch);
    begin
      got = 1'b0;
      for (k = 0; k < 3000 && !got; k = k + 1) begin
        @(negedge sys_clk_in);
        crdy = k[0];
        @(posedge sys_clk_in);
        if (cval === 1'b1 && crdy) got = 1'b1;
        ch = cdat;
      end
      if (!got) begin
        n_mismatch = n_mismatch + 1;
        end_sim;
      end
    end
  endtask
  task t_pols;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        @(negedge sys_clk_in);
        {pol2, pol1} = i[1:0];
        t_read(12'h000);
        t_read(12'hfff);
        t_read({i[1:0], 10'h2a5});
      end
      $display("t_pols done");
    end
  endtask
  task t_dump;
    begin
      @(negedge sys_clk_in);
      dump = 1'b1;
      rd_req = 1'b1;
      @(negedge sys_clk_in);
      dump = 1'b0;
      sum = 8'h00;
      for (i = 1; i <= 81; i = i + 1) begin
        get_ch(c);
        w = (i - 5) >> 1;
        e = 8'h20;
        if (i <= 3) e = 8'h30;
        else if (i >= 5 && i <= 68) e = hx(i[0] ? w[7:4] : w[3:0]);
        else if (i == 69) e = hx(cks[7:4]);
        else if (i == 70) e = hx(cks[3:0]);
        else if (i == 73) e = 8'h30 + pol2;
        else if (i == 74) e = 8'h30 + pol1;
        else if (i >= 75 && i <= 80) e = ID[8 * (80 - i) +: 8];
        else if (i == 81) e = 8'h0a;
        chk(c, e);
        if (i <= 68 && i != 4) sum = sum + e;
        if (i == 68) cks = 8'h00 - sum;
      end
      chk({7'h00, busy}, 8'h01);
      chk({7'h00, ack}, 8'h00);
      $display("t_dump done");
    end
  endtask
  task t_reset;
    begin
      @(negedge sys_clk_in);
      rd_req = 1'b0;
      reset_n_in = 1'b0;
      @(negedge sys_clk_in);
      chk({busy, cval, cs1, cs2}, {2'b00, ~pol1, ~pol2});
      reset_n_in = 1'b1;
      t_read(12'h123);
      $display("t_reset done");
    end
  endtask
  initial begin
    repeat (3) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    t_pols;
    t_dump;
    t_reset;
    end_sim;
  end
endmodule
`default_nettype wire
